// file: scih_pkg.sv
// Constants shared by the interrupt and host bus port of the serial controller.
//
// Overview of operation
// - Acknowledge cycle drives the programmed vector; vector also readable in either channel.
// - Three vector bits may carry cause status; channel B reads always include it.
// - Six sources each keep pending, under-service and enable bits.
// - Requests need the source enable and master enable; source enables are write-only.
// - Pending never sets while its enable is clear; pending bits read in channel A.
// - Interrupt request is asserted while a pending bit is set and chain input is high.
// - Any under-service bit blocks lower internal sources and drops chain output.
// - Acknowledge cycle sets under-service bit of requesting source if nothing higher requests.
// - Channel A above B; receive, transmit, external/status within each channel.
// - Transmit pending sets when buffer empties, only after a character was written.
// - Receive interrupt modes: first character, every character, special condition only.
// - Overrun, framing or parity error form special condition, differing only in status.
// - In first-character mode special conditions interrupt after the first character did.
// - External/status fires on modem input edges, underrun, baud zero count and break.
// - Wait/request output works as CPU wait or DMA request line under control bits.
// - Direct addressing takes channel from bit 0 or 5; bits 4..1 are the register.
// - Pointer variant: host writes three pointer bits, next access uses that register.
// - Pointer bits clear automatically after the following register access.
// - Address, first select and acknowledge latch on address strobe rise; reads drive data.
// - Writes capture bus data while data strobe is low with second select high.
// - In acknowledge cycles address, selects and read/write are ignored.
// - Pending with chain input high at data strobe fall claims the acknowledge cycle.
// - Chain output high only with chain input high, nothing in service and, during acknowledge cycles, nothing requesting.
// - Interrupt request is an active-low open-drain output.
// - Wait/request defaults to the wait function after reset.
package scih_pkg;

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_COMMAND   = 4'h0;
  localparam logic [3:0] REG_RX_ERROR  = 4'h1;
  localparam logic [3:0] REG_VECTOR    = 4'h2;
  localparam logic [3:0] REG_PENDING   = 4'h3;
  localparam logic [3:0] REG_XFER_MODE = 4'h1;
  localparam logic [3:0] REG_MASTER    = 4'h9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CMD_LSB      = 3;
  localparam int XM_EXT_IE    = 0;
  localparam int XM_TX_IE     = 1;
  localparam int XM_RX_LSB    = 3;
  localparam int XM_WR_DIR    = 5;
  localparam int XM_WR_FUNC   = 6;
  localparam int XM_WR_EN     = 7;
  localparam int MC_VIS       = 0;
  localparam int MC_NO_VECTOR = 1;
  localparam int MC_SHIFT_LFT = 2;
  localparam int MC_MIE       = 3;
  localparam int VEC_STAT_LSB = 1;

  // ----------------------------------------------------------------
  // Commands, receive modes, source types
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_RESET_EXT = 3'h2;
  localparam logic [2:0] CMD_RESET_TX  = 3'h5;
  localparam logic [2:0] CMD_RESET_IUS = 3'h7;
  localparam logic [1:0] RX_OFF        = 2'h0;
  localparam logic [1:0] RX_FIRST      = 2'h1;
  localparam logic [1:0] RX_ALL        = 2'h2;
  localparam logic [1:0] RX_SPECIAL    = 2'h3;
  localparam logic [1:0] ST_TX         = 2'h0;
  localparam logic [1:0] ST_EXT        = 2'h1;
  localparam logic [1:0] ST_RX         = 2'h2;
  localparam logic [1:0] ST_SPECIAL    = 2'h3;
  localparam logic [2:0] ST_NONE       = 3'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_VECTOR = 8'h00;
  localparam logic [7:0] RST_MASTER = 8'h00;
  localparam logic [7:0] RST_XMODE  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 40;
  localparam int RECOVERY_CLK = 6;
  localparam int RECOVERY_NS  = 200;
  localparam int RECOVERY_CYC = RECOVERY_CLK + (RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_WIDTH   = 21;

endpackage : scih_pkg

// file: scih_sync.sv
// Two flip-flop synchroniser for pins that are asynchronous to clk.
`timescale 1ns/1ps
module scih_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage is read by the second stage only.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta     <= '1;
      sync_out <= '1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : scih_sync

// file: scih_port.sv
// Interrupt logic and multiplexed host bus port of the two-channel serial controller.
`timescale 1ns/1ps
module scih_port #(
  parameter bit PTR_ADDR = 1'b0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Multiplexed host bus
  input  wire logic        addr_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic        select_latched_n,
  input  wire logic        select_level_hi,
  input  wire logic        read_write,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  // Interrupt daisy chain and request
  input  wire logic        irq_ack_in,
  input  wire logic        chain_enable_in,
  output logic             chain_enable_out,
  output logic             irq_req_out,
  output logic             irq_req_oe,
  // Channel datapath events, index 1 is channel A
  input  wire logic [1:0]  rx_char_in,
  input  wire logic [1:0]  rx_special_in,
  input  wire logic [1:0]  rx_data_read,
  input  wire logic [1:0]  tx_buf_write,
  input  wire logic [1:0]  tx_buf_empty,
  input  wire logic [1:0]  tx_underrun,
  input  wire logic [1:0]  brg_zero,
  input  wire logic [1:0]  break_detect,
  input  wire logic [1:0]  rx_ready,
  input  wire logic [1:0]  tx_ready,
  input  wire logic [15:0] rx_error_status,
  // Modem pins, active low
  input  wire logic [1:0]  cts_n,
  input  wire logic [1:0]  dcd_n,
  input  wire logic [1:0]  ri_n,
  // Wait/request pins and recovery monitor
  output logic      [1:0]  wait_req_out,
  output logic      [1:0]  wait_req_oe,
  output logic             recovery_error
);

  // ----------------------------------------------------------------
  // Priority helpers
  // ----------------------------------------------------------------
  // Returns {valid, index} of the highest pending source not blocked by service.
  function automatic logic [3:0] top_req(input logic [5:0] ip, input logic [5:0] irq_in_service_bit);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < 6; i++) begin
      if (ip[i] && ((irq_in_service_bit >> i) == 6'h00)) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction : top_req

  function automatic logic [5:0] top_bit(input logic [5:0] v);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (v[i]) begin
        res = 6'h01 << i;
      end
    end
    return res;
  endfunction : top_bit

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [scih_pkg::SYNC_WIDTH-1:0] s_pins;
  logic s_as, s_ds, s_ack_n, s_cs0_n, s_cs1, s_rw, s_iei;
  logic [7:0] s_ad;
  logic [1:0] s_cts, s_dcd, s_ri;

  // Strobes settle here; the host recovery gap covers this latency.
  scih_sync #(.WIDTH(scih_pkg::SYNC_WIDTH)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({chain_enable_in, ri_n, dcd_n, cts_n, ad_in, read_write, select_level_hi,
                select_latched_n, irq_ack_in, data_strobe_n, addr_strobe_n}),
    .sync_out (s_pins)
  );
  assign {s_iei, s_ri, s_dcd, s_cts, s_ad, s_rw, s_cs1, s_cs0_n, s_ack_n, s_ds, s_as} = s_pins;

  // ----------------------------------------------------------------
  // Bus cycle decode
  // ----------------------------------------------------------------
  logic       as_d, ds_d, lat_cs0_n, lat_ack_n;
  logic [7:0] lat_addr, vector, master;
  logic [7:0] xmode [2];
  logic [2:0] ptr;
  logic [5:0] ip, irq_in_service_bit;
  logic [1:0] mdm_d [3];
  logic [4:0] rec_cnt;

  wire as_rise    = s_as && !as_d;
  wire ds_fall    = !s_ds && ds_d;
  wire ds_rise    = s_ds && !ds_d;
  wire shift_left = master[scih_pkg::MC_SHIFT_LFT];
  wire master_irq_enable        = master[scih_pkg::MC_MIE];
  wire chan_sel   = shift_left ? lat_addr[5] : lat_addr[0];
  wire [3:0] reg_sel = PTR_ADDR ? {1'b0, ptr} : lat_addr[4:1];
  wire acc_sel    = lat_ack_n && !lat_cs0_n && s_cs1;
  wire bus_rd     = ds_fall && acc_sel && s_rw;
  wire bus_wr     = ds_fall && acc_sel && !s_rw;
  wire ack_ds     = ds_fall && !lat_ack_n;

  // ----------------------------------------------------------------
  // Interrupt priority and vector
  // ----------------------------------------------------------------
  wire [3:0] top      = top_req(ip, irq_in_service_bit);
  wire [2:0] top_idx  = top[2:0];
  wire       req_any  = top[3] && master_irq_enable;
  wire       claim    = ack_ds && s_iei && req_any;
  logic [1:0] spec;
  // Position inside the channel: 0 external/status, 1 transmit, 2 receive.
  wire       top_a    = top_idx >= 3'h3;
  wire [1:0] top_pos  = top_a ? 2'(top_idx - 3'h3) : top_idx[1:0];
  wire [1:0] top_rx   = spec[top_a] ? scih_pkg::ST_SPECIAL : scih_pkg::ST_RX;
  wire [1:0] top_type = (top_pos == 2'h2) ? top_rx :
                        (top_pos == 2'h1) ? scih_pkg::ST_TX : scih_pkg::ST_EXT;
  wire [2:0] status   = top[3] ? {top_a, top_type} : scih_pkg::ST_NONE;
  wire [7:0] vec_mod  = {vector[7:4], status, vector[0]};
  wire [7:0] vec_out  = master[scih_pkg::MC_VIS] ? vec_mod : vector;

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  wire       c = chan_sel;
  wire [7:0] main_status = {~s_ri[c], 1'b0, ~s_cts[c], 1'b0, ~s_dcd[c], tx_ready[c], 1'b0,
                            rx_ready[c]};
  wire [7:0] rd_data = (reg_sel == scih_pkg::REG_COMMAND)  ? main_status :
                       (reg_sel == scih_pkg::REG_RX_ERROR) ? rx_error_status[8*c +: 8] :
                       (reg_sel == scih_pkg::REG_VECTOR)   ? (c ? vector : vec_mod) :
                       (reg_sel == scih_pkg::REG_PENDING && c) ? {2'b00, ip} : 8'h00;

  // ----------------------------------------------------------------
  // Register writes and commands
  // ----------------------------------------------------------------
  wire       wr_cmd  = bus_wr && reg_sel == scih_pkg::REG_COMMAND;
  wire [2:0] cmd     = s_ad[scih_pkg::CMD_LSB +: 3];
  wire       wr_vec  = bus_wr && reg_sel == scih_pkg::REG_VECTOR;
  wire       wr_mast = bus_wr && reg_sel == scih_pkg::REG_MASTER;
  wire       wr_xm   = bus_wr && reg_sel == scih_pkg::REG_XFER_MODE;
  wire [2:0] next_ptr = (PTR_ADDR && (bus_rd || bus_wr) && ptr != 3'h0) ? 3'h0 :
                        (PTR_ADDR && wr_cmd) ? s_ad[2:0] : ptr;
  wire [5:0] next_ius = claim ? (irq_in_service_bit | (6'h01 << top_idx)) :
                        (wr_cmd && cmd == scih_pkg::CMD_RESET_IUS) ? (irq_in_service_bit & ~top_bit(irq_in_service_bit)) : irq_in_service_bit;

  always_ff @(posedge clk) begin
    if (reset) begin
      as_d      <= 1'b1;
      ds_d      <= 1'b1;
      lat_addr  <= 8'h00;
      lat_cs0_n <= 1'b1;
      lat_ack_n <= 1'b1;
      ptr       <= 3'h0;
      vector    <= scih_pkg::RST_VECTOR;
      master    <= scih_pkg::RST_MASTER;
      irq_in_service_bit       <= 6'h00;
    end else begin
      as_d <= s_as;
      ds_d <= s_ds;
      if (as_rise) begin
        lat_addr  <= s_ad;
        lat_cs0_n <= s_cs0_n;
        lat_ack_n <= s_ack_n;
      end else if (ds_rise) begin
        lat_ack_n <= 1'b1;
      end
      ptr <= next_ptr;
      if (wr_vec) begin
        vector <= s_ad;
      end
      if (wr_mast) begin
        master <= s_ad;
      end
      irq_in_service_bit <= next_ius;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel sources and wait/request
  // ----------------------------------------------------------------
  logic [5:0] ie, next_ip;
  logic [1:0] first_done, tx_loaded, next_first, next_loaded, next_spec;
  logic [1:0] next_wr_out, next_wr_oe;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      wire [1:0] rx_mode = xmode[g][scih_pkg::XM_RX_LSB +: 2];
      wire xm_here  = wr_xm && chan_sel == 1'(g);
      wire cmd_here = wr_cmd && chan_sel == 1'(g);
      wire mdm_edge = (s_cts[g] != mdm_d[0][g]) || (s_dcd[g] != mdm_d[1][g]) ||
                      (s_ri[g] != mdm_d[2][g]);
      wire ext_set  = mdm_edge || tx_underrun[g] || brg_zero[g] || break_detect[g];
      wire tx_set   = tx_buf_empty[g] && tx_loaded[g];
      wire ch_set   = rx_char_in[g] && (rx_mode == scih_pkg::RX_ALL ||
                      (rx_mode == scih_pkg::RX_FIRST && !first_done[g]));
      wire sp_set   = rx_special_in[g] && (rx_mode == scih_pkg::RX_ALL ||
                      rx_mode == scih_pkg::RX_SPECIAL ||
                      (rx_mode == scih_pkg::RX_FIRST && first_done[g]));
      wire [2:0] clr = {rx_data_read[g], cmd_here && cmd == scih_pkg::CMD_RESET_TX,
                        cmd_here && cmd == scih_pkg::CMD_RESET_EXT};
      wire [2:0] set = {ch_set || sp_set, tx_set, ext_set};
      wire wr_ready  = xmode[g][scih_pkg::XM_WR_DIR] ? rx_ready[g] : tx_ready[g];
      wire wr_en     = xmode[g][scih_pkg::XM_WR_EN];

      assign ie[3*g +: 3] = {rx_mode != scih_pkg::RX_OFF, xmode[g][scih_pkg::XM_TX_IE],
                             xmode[g][scih_pkg::XM_EXT_IE]};
      // A set arriving with its clear wins; a disabled source never holds pending.
      assign next_ip[3*g +: 3] = ((ip[3*g +: 3] & ~clr) | set) & ie[3*g +: 3];
      assign next_first[g]  = xm_here ? 1'b0 : (first_done[g] || ch_set);
      assign next_loaded[g] = tx_buf_write[g] || (tx_loaded[g] && !tx_buf_empty[g]);
      assign next_spec[g]   = sp_set || (spec[g] && !rx_data_read[g]);
      // Wait drives low while not ready; request drives low while ready.
      assign next_wr_out[g] = xmode[g][scih_pkg::XM_WR_FUNC] ? !wr_ready : 1'b0;
      assign next_wr_oe[g]  = xmode[g][scih_pkg::XM_WR_FUNC] ? wr_en : (wr_en && !wr_ready);

      always_ff @(posedge clk) begin
        if (reset) begin
          xmode[g] <= scih_pkg::RST_XMODE;
        end else if (xm_here) begin
          xmode[g] <= s_ad;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Source state, outputs and recovery monitor
  // ----------------------------------------------------------------
  wire next_req = req_any && s_iei;
  wire next_ieo = s_iei && (irq_in_service_bit == 6'h00) && !(!lat_ack_n && req_any);

  always_ff @(posedge clk) begin
    if (reset) begin
      ip <= 6'h00;
      first_done <= 2'b00;
      tx_loaded <= 2'b00;
      spec <= 2'b00;
      mdm_d <= '{2'b11, 2'b11, 2'b11};
      irq_req_out <= 1'b0;
      irq_req_oe <= 1'b0;
      chain_enable_out <= 1'b0;
      wait_req_out <= 2'b00;
      wait_req_oe <= 2'b00;
      ad_out <= 8'h00;
      ad_oe <= 1'b0;
      rec_cnt <= 5'h00;
      recovery_error <= 1'b0;
    end else begin
      ip <= next_ip;
      first_done <= next_first;
      tx_loaded <= next_loaded;
      spec <= next_spec;
      mdm_d <= '{s_cts, s_dcd, s_ri};
      irq_req_oe <= next_req;
      chain_enable_out <= next_ieo;
      wait_req_out <= next_wr_out;
      wait_req_oe <= next_wr_oe;
      if (claim && !master[scih_pkg::MC_NO_VECTOR]) begin
        ad_out <= vec_out;
        ad_oe <= 1'b1;
      end else if (bus_rd) begin
        ad_out <= rd_data;
        ad_oe <= 1'b1;
      end else if (s_ds) begin
        ad_oe <= 1'b0;
      end
      if (ds_rise) begin
        rec_cnt <= 5'h00;
      end else if (rec_cnt != 5'h1f) begin
        rec_cnt <= rec_cnt + 5'h01;
      end
      if (ds_fall && rec_cnt < 5'(scih_pkg::RECOVERY_CYC)) begin
        recovery_error <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_vector_out;
    claim && !master[scih_pkg::MC_NO_VECTOR] |=> ad_oe && ad_out == $past(vec_out);
  endproperty
  a_vector_out: assert property (p_vector_out) else $error("vector not driven");

  property p_chan_a_plain;
    bus_rd && reg_sel == scih_pkg::REG_VECTOR && chan_sel |=> ad_out == vector;
  endproperty
  a_chan_a_plain: assert property (p_chan_a_plain) else $error("channel A vector modified");

  property p_ip_needs_ie;
    (ip & ~$past(ie)) == 6'h00;
  endproperty
  a_ip_needs_ie: assert property (p_ip_needs_ie) else $error("pending without enable");

  property p_irq_cause;
    irq_req_oe |-> $past(s_iei) && $past(master_irq_enable) && $past(ip) != 6'h00;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without cause");

  property p_ius_blocks_chain;
    irq_in_service_bit != 6'h00 |=> !chain_enable_out;
  endproperty
  a_ius_blocks_chain: assert property (p_ius_blocks_chain) else $error("chain open");

  property p_claim_sets_ius;
    claim |=> irq_in_service_bit[$past(top_idx)];
  endproperty
  a_claim_sets_ius: assert property (p_claim_sets_ius) else $error("service bit not set");

  property p_priority;
    ip[5] && irq_in_service_bit == 6'h00 |-> top_idx == 3'h5;
  endproperty
  a_priority: assert property (p_priority) else $error("channel A receive not first");

  property p_tx_loaded;
    $rose(ip[4]) |-> $past(tx_loaded[1]);
  endproperty
  a_tx_loaded: assert property (p_tx_loaded) else $error("transmit pending unloaded");

  property p_ptr_clear;
    PTR_ADDR && (bus_rd || bus_wr) && ptr != 3'h0 |=> ptr == 3'h0;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");

  property p_ack_ignores;
    !lat_ack_n |-> !bus_rd && !bus_wr;
  endproperty
  a_ack_ignores: assert property (p_ack_ignores) else $error("access in acknowledge");

endmodule : scih_port

// file: scih_host.sv
// Host bus master model that runs read, write and acknowledge cycles on the port.
`timescale 1ns/1ps
module scih_host (
  // Clock
  input  wire logic       clk,
  // Multiplexed bus driven by the host
  output logic            addr_strobe_n,
  output logic            data_strobe_n,
  output logic            select_latched_n,
  output logic            select_level_hi,
  output logic            read_write,
  output logic            irq_ack_in,
  output logic      [7:0] ad_in,
  // Device answer
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe
);
  initial begin
    addr_strobe_n    = 1'b1;
    data_strobe_n    = 1'b1;
    select_latched_n = 1'b1;
    select_level_hi  = 1'b0;
    read_write       = 1'b1;
    irq_ack_in       = 1'b1;
    ad_in            = 8'h00;
  end

  // ----------------------------------------------------------------
  // One bus cycle
  // ----------------------------------------------------------------
  // Acknowledge cycles drive inactive selects and write direction, which must be ignored.
  task automatic cycle(input logic ack, input logic rd, input logic [7:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata,
                       output logic seen);
    int n;
    seen  = 1'b0;
    rdata = 8'h00;
    @(negedge clk);
    addr_strobe_n    = 1'b0;
    ad_in            = addr;
    select_latched_n = ack;
    irq_ack_in       = ~ack;
    repeat (2) @(negedge clk);
    addr_strobe_n    = 1'b1;
    repeat (4) @(negedge clk);
    ad_in            = rd ? ~addr : wdata;
    read_write       = ack ? 1'b0 : rd;
    select_level_hi  = ~ack;
    data_strobe_n    = 1'b0;
    for (n = 0; n < 10 && !seen; n++) begin
      @(negedge clk);
      if (rd && ad_oe === 1'b1) begin
        seen  = 1'b1;
        rdata = ad_out;
      end
    end
    @(negedge clk);
    data_strobe_n    = 1'b1;
    select_level_hi  = 1'b0;
    select_latched_n = 1'b1;
    irq_ack_in       = 1'b1;
    ad_in            = ~ad_in;
    repeat (12) @(negedge clk);
  endtask : cycle
endmodule : scih_host

// file: tb_top.sv
// Self-checking testbench of the interrupt logic and host bus port.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, reset = 1'b1;
  logic as_n, ds_n, cs0_n, cs1, rw, ack_n, chain_enable_in, chain_enable_out;
  logic [7:0] ad_in, ad_out, d, vec, ptr_ad;
  logic ad_oe, irq_req_out, irq_req_oe, recovery_error, seen;
  logic [1:0] rx_char_in, rx_special_in, rx_data_read, tx_buf_write, tx_buf_empty;
  logic [1:0] brg_zero, rx_ready, tx_ready, wait_req_out, wait_req_oe;
  logic [1:0] tx_underrun, break_detect, cts_n, dcd_n, ri_n;
  logic [15:0] rx_error_status;
  int failures = 0, n_tests = 0, seed = 8967, m_ip, i;

  always #20 clk = ~clk;

  scih_port #(.PTR_ADDR(1'b0)) u_dut (.clk(clk), .reset(reset), .addr_strobe_n(as_n),
    .data_strobe_n(ds_n), .select_latched_n(cs0_n), .select_level_hi(cs1), .read_write(rw),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .irq_ack_in(ack_n),
    .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
    .irq_req_out(irq_req_out), .irq_req_oe(irq_req_oe), .rx_char_in(rx_char_in),
    .rx_special_in(rx_special_in), .rx_data_read(rx_data_read), .tx_buf_write(tx_buf_write),
    .tx_buf_empty(tx_buf_empty), .tx_underrun(tx_underrun), .brg_zero(brg_zero),
    .break_detect(break_detect), .rx_ready(rx_ready), .tx_ready(tx_ready),
    .rx_error_status(rx_error_status), .cts_n(cts_n), .dcd_n(dcd_n), .ri_n(ri_n),
    .wait_req_out(wait_req_out), .wait_req_oe(wait_req_oe), .recovery_error(recovery_error));

  // Pointer-addressed variant listening to the same bus; only its data output is watched.
  scih_port #(.PTR_ADDR(1'b1)) u_ptr (.clk(clk), .reset(reset), .addr_strobe_n(as_n),
    .data_strobe_n(ds_n), .select_latched_n(cs0_n), .select_level_hi(cs1), .read_write(rw),
    .ad_in(ad_in), .ad_out(ptr_ad), .ad_oe(), .irq_ack_in(ack_n),
    .chain_enable_in(chain_enable_in), .chain_enable_out(), .irq_req_out(), .irq_req_oe(),
    .rx_char_in(rx_char_in), .rx_special_in(rx_special_in), .rx_data_read(rx_data_read),
    .tx_buf_write(tx_buf_write), .tx_buf_empty(tx_buf_empty), .tx_underrun(tx_underrun),
    .brg_zero(brg_zero), .break_detect(break_detect), .rx_ready(rx_ready), .tx_ready(tx_ready),
    .rx_error_status(rx_error_status), .cts_n(cts_n), .dcd_n(dcd_n), .ri_n(ri_n),
    .wait_req_out(), .wait_req_oe(), .recovery_error());

  scih_host u_host (.clk(clk), .addr_strobe_n(as_n), .data_strobe_n(ds_n),
    .select_latched_n(cs0_n), .select_level_hi(cs1), .read_write(rw), .irq_ack_in(ack_n),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] r, input logic ch, input logic [7:0] v);
    u_host.cycle(1'b0, 1'b0, {3'b000, r, ch}, v, d, seen);
  endtask : wr

  task automatic rd(input logic [3:0] r, input logic ch);
    u_host.cycle(1'b0, 1'b1, {3'b000, r, ch}, 8'h00, d, seen);
  endtask : rd

  function automatic logic [7:0] exp_vec(input logic [7:0] v, input logic [2:0] s);
    return {v[7:4], s, v[0]};
  endfunction : exp_vec

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  initial begin
    #(40 * 5000);
    failures++;
    results();
  end

  initial begin
    {rx_char_in, rx_special_in, rx_data_read, tx_buf_write, tx_buf_empty, brg_zero} = '0;
    {rx_ready, tx_ready} = 4'h0;
    {tx_underrun, break_detect} = 4'h0;
    {cts_n, dcd_n, ri_n} = 6'h3f;
    chain_enable_in = 1'b1;
    rx_error_status = 16'($random(seed));
    vec = 8'($random(seed));
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check(irq_req_oe, 1'b0);
    check(chain_enable_out, 1'b1);
    check(irq_req_out, 1'b0);
    wr(scih_pkg::REG_VECTOR, 1'b1, vec);
    rd(scih_pkg::REG_VECTOR, 1'b1); check(d, vec);
    rd(scih_pkg::REG_VECTOR, 1'b0); check(d, exp_vec(vec, scih_pkg::ST_NONE));
    rd(scih_pkg::REG_RX_ERROR, 1'b1); check(d, rx_error_status[15:8]);
    $display("test registers done");
    wr(scih_pkg::REG_MASTER, 1'b1, 8'h09);
    wr(scih_pkg::REG_XFER_MODE, 1'b1, 8'h02);
    wr(scih_pkg::REG_XFER_MODE, 1'b0, 8'h01);
    @(negedge clk) tx_buf_empty = 2'b11;
    @(negedge clk) tx_buf_empty = 2'b00;
    repeat (3) @(negedge clk);
    check(irq_req_oe, 1'b0);
    @(negedge clk) tx_buf_write = 2'b11;
    @(negedge clk) tx_buf_write = 2'b00;
    @(negedge clk) tx_buf_empty = 2'b11;
    @(negedge clk) {tx_buf_empty, brg_zero} = 4'b0001;
    @(negedge clk) brg_zero = 2'b00;
    m_ip = 'h11;
    rd(scih_pkg::REG_PENDING, 1'b1); check(d, m_ip[7:0]);
    check(irq_req_oe, 1'b1);
    chain_enable_in = 1'b0;
    repeat (4) @(negedge clk);
    check(irq_req_oe, 1'b0);
    check(chain_enable_out, 1'b0);
    chain_enable_in = 1'b1;
    u_host.cycle(1'b1, 1'b1, 8'hFF, 8'h00, d, seen);
    check(seen, 1'b1);
    check(d, exp_vec(vec, {1'b1, scih_pkg::ST_TX}));
    check(chain_enable_out, 1'b0);
    wr(scih_pkg::REG_COMMAND, 1'b1, {2'b00, scih_pkg::CMD_RESET_TX, 3'b000});
    wr(scih_pkg::REG_COMMAND, 1'b1, {2'b00, scih_pkg::CMD_RESET_IUS, 3'b000});
    u_host.cycle(1'b1, 1'b1, 8'hFF, 8'h00, d, seen);
    check(d, exp_vec(vec, {1'b0, scih_pkg::ST_EXT}));
    wr(scih_pkg::REG_COMMAND, 1'b0, {2'b00, scih_pkg::CMD_RESET_EXT, 3'b000});
    wr(scih_pkg::REG_COMMAND, 1'b0, {2'b00, scih_pkg::CMD_RESET_IUS, 3'b000});
    check(irq_req_oe, 1'b0);
    check(chain_enable_out, 1'b1);
    $display("test interrupts done");
    for (i = 0; i < 4; i++) begin
      wr(scih_pkg::REG_XFER_MODE, 1'b1, 8'(i << scih_pkg::XM_RX_LSB));
      @(negedge clk) rx_char_in = 2'b10;
      @(negedge clk) rx_char_in = 2'b00;
      rd(scih_pkg::REG_PENDING, 1'b1); check(d, (i == 1 || i == 2) ? 8'h20 : 8'h00);
      @(negedge clk) rx_special_in = 2'b10;
      @(negedge clk) rx_special_in = 2'b00;
      rd(scih_pkg::REG_PENDING, 1'b1); check(d, (i != 0) ? 8'h20 : 8'h00);
      @(negedge clk) rx_data_read = 2'b10;
      @(negedge clk) rx_data_read = 2'b00;
    end
    $display("test receive modes done");
    cts_n = 2'b10;
    rd(scih_pkg::REG_PENDING, 1'b1); check(d, 8'h01);
    cts_n = 2'b11;
    wr(scih_pkg::REG_COMMAND, 1'b0, {2'b00, scih_pkg::CMD_RESET_EXT, 3'b000});
    rd(scih_pkg::REG_PENDING, 1'b1); check(d, 8'h00);
    wr(scih_pkg::REG_XFER_MODE, 1'b1, 8'h80);
    repeat (4) @(negedge clk);
    check({wait_req_oe[1], wait_req_out[1]}, 2'b10);
    tx_ready = 2'b10;
    repeat (4) @(negedge clk);
    check(wait_req_oe[1], 1'b0);
    wr(scih_pkg::REG_XFER_MODE, 1'b1, 8'hC0);
    check({wait_req_oe[1], wait_req_out[1]}, 2'b10);
    tx_ready = 2'b00;
    repeat (4) @(negedge clk);
    check({wait_req_oe[1], wait_req_out[1]}, 2'b11);
    rd(scih_pkg::REG_COMMAND, 1'b1);
    vec = 8'($random(seed));
    wr(scih_pkg::REG_COMMAND, 1'b1, 8'(scih_pkg::REG_VECTOR));
    wr(scih_pkg::REG_VECTOR, 1'b1, vec);
    wr(scih_pkg::REG_COMMAND, 1'b1, 8'(scih_pkg::REG_VECTOR));
    rd(scih_pkg::REG_VECTOR, 1'b1); check(d, vec); check(ptr_ad, vec);
    rd(scih_pkg::REG_VECTOR, 1'b1); check(ptr_ad, 8'h00);
    check(recovery_error, 1'b0);
    $display("test wait request done");
    results();
  end
endmodule : tb_top
